// ### design/pbc_top.sv
// PHY basic control register bank, reached over the management serial bus and the SPI path
// Operation
// - Writing one to bit 15 soft-resets the PHY; self-clears when done.
// - Bit 14 loops traffic back at the port's MAC-to-PHY interface.
// - Bit 13 forces 100 Mbps when one, 10 Mbps when zero; resets one.
// - Bit 12 enables auto-negotiation; resets to one.
// - Bit 11 powers the PHY down; resets to zero.
// - Bit 10 isolates the PHY from its transmit pair; resets zero.
// - Writing one to bit 9 restarts auto-negotiation; resets zero.
// - Bit 8 forces full duplex when one, half when zero; resets one.
// - Bit 5 picks the crossover algorithm, alternate when one; resets one.
// - With auto crossover off, bit 4 gives MDI when one, MDIX zero.
// - Bit 3 disables automatic crossover detection; zero leaves it on.
// - Bit 2 disables far-end fault detection; resets zero.
// - Every register is reachable over both the serial bus and SPI.
// - PHY addresses 1 to 4 map to ports; only listed registers supported.
// - Bits 1 and 0 disable transmitter and LED; read-write, reset zero.
`timescale 1ns/100ps
module pbc_top #(
	parameter int NUM_PORTS = 4
) (
	input wire logic clk, // System clock, 20 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic mdc, // Management clock pin
	input wire logic mdio_i, // Management data pin, input side
	output logic mdio_o_ff, // Management data pin, output side
	output logic mdio_oen_ff, // Management data enable, low drives
	input wire pbc_pkg::pbc_spi_req_t spi_req, // SPI register path request
	output logic [15:0] spi_rdata_ff, // SPI read data
	output logic spi_rvalid_ff, // SPI read data valid pulse
	output pbc_pkg::pbc_port_ctl_t [3:0] port_ctl_ff // Per-port PHY controls
);
	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
		$error("NUM_PORTS must lie between 1 and 4");
	end

	typedef enum logic [2:0] {M_PRE, M_HDR, M_WR, M_RD} pbc_mstate_t;

	// Store only writable bits so reserved bits stay zero
	function automatic logic [15:0] apply_write(input logic [15:0] d);
		apply_write = d & pbc_pkg::CTRL_WMASK;
	endfunction

	// True when a management address falls inside the port range
	function automatic logic addr_hits(input logic [4:0] phyad);
		addr_hits = (phyad >= pbc_pkg::PHYAD_FIRST) &&
			(phyad < pbc_pkg::PHYAD_FIRST + 5'(NUM_PORTS));
	endfunction

	logic [15:0] ctl_ff [4];
	logic [4:0] rst_cnt_ff [4];
	logic mdc_s1_ff, mdc_s2_ff, mdc_s3_ff, mdc_lvl_ff;
	logic dat_s1_ff, dat_s2_ff, dat_s3_ff;
	logic mdc_rise, mdc_fall;
	pbc_mstate_t mstate_ff;
	logic [5:0] ones_ff;
	logic [4:0] cnt_ff;
	logic [13:0] hdr_ff;
	logic [15:0] shift_ff;
	logic [1:0] mport_ff;
	logic [4:0] mreg_ff;
	logic mdio_wr_ff;
	logic wr_valid;
	logic [1:0] wr_port;
	logic [15:0] wr_data;
	logic [13:0] nxt_hdr;
	logic [15:0] nxt_shift;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mdc_s1_ff <= 1'b0;
			mdc_s2_ff <= 1'b0;
			mdc_s3_ff <= 1'b0;
			dat_s1_ff <= 1'b1;
			dat_s2_ff <= 1'b1;
			dat_s3_ff <= 1'b1;
		end else begin
			mdc_s1_ff <= mdc;
			mdc_s2_ff <= mdc_s1_ff;
			mdc_s3_ff <= mdc_s2_ff;
			dat_s1_ff <= mdio_i;
			dat_s2_ff <= dat_s1_ff;
			dat_s3_ff <= dat_s2_ff;
		end
	end

	// Filtered clock level, edges derived from it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mdc_lvl_ff <= 1'b0;
		end else if (mdc_s2_ff == mdc_s3_ff) begin
			mdc_lvl_ff <= mdc_s3_ff;
		end
	end
	assign mdc_rise = (mdc_s2_ff == mdc_s3_ff) && mdc_s3_ff && !mdc_lvl_ff;
	assign mdc_fall = (mdc_s2_ff == mdc_s3_ff) && !mdc_s3_ff && mdc_lvl_ff;
	assign nxt_hdr = {hdr_ff[12:0], dat_s3_ff};
	assign nxt_shift = {shift_ff[14:0], dat_s3_ff};

	// ------------------------------------------------------------
	// Management frame receiver
	// ------------------------------------------------------------
	// Sampled on the rising management clock; reads turn around on falls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mstate_ff <= M_PRE;
			ones_ff <= 6'h00;
			cnt_ff <= 5'h00;
			hdr_ff <= 14'h0000;
			shift_ff <= 16'h0000;
			mport_ff <= 2'h0;
			mreg_ff <= 5'h00;
			mdio_wr_ff <= 1'b0;
		end else begin
			mdio_wr_ff <= 1'b0;
			case (mstate_ff)
				M_PRE: begin
					if (mdc_rise) begin
						if (dat_s3_ff) begin
							if (ones_ff != pbc_pkg::PREAMBLE_ONES) begin
								ones_ff <= ones_ff + 6'h01;
							end
						end else if (ones_ff == pbc_pkg::PREAMBLE_ONES) begin
							mstate_ff <= M_HDR;
							hdr_ff <= nxt_hdr;
							cnt_ff <= 5'h01;
							ones_ff <= 6'h00;
						end else begin
							ones_ff <= 6'h00;
						end
					end
				end
				M_HDR: begin
					if (mdc_rise) begin
						hdr_ff <= nxt_hdr;
						cnt_ff <= cnt_ff + 5'h01;
						if (cnt_ff == pbc_pkg::HDR_LAST) begin
							cnt_ff <= 5'h00;
							mport_ff <= 2'(nxt_hdr[9:5] - pbc_pkg::PHYAD_FIRST);
							mreg_ff <= nxt_hdr[4:0];
							if (nxt_hdr[13:12] != pbc_pkg::FRAME_START ||
								!addr_hits(nxt_hdr[9:5])) begin
								mstate_ff <= M_PRE;
							end else if (nxt_hdr[11:10] == pbc_pkg::OP_WRITE) begin
								mstate_ff <= M_WR;
							end else if (nxt_hdr[11:10] == pbc_pkg::OP_READ) begin
								mstate_ff <= M_RD;
								shift_ff <= (nxt_hdr[4:0] == pbc_pkg::REG_CTRL) ?
									ctl_ff[2'(nxt_hdr[9:5] - pbc_pkg::PHYAD_FIRST)] : 16'h0000;
							end else begin
								mstate_ff <= M_PRE;
							end
						end
					end
				end
				M_WR: begin
					if (mdc_rise) begin
						cnt_ff <= cnt_ff + 5'h01;
						if (cnt_ff >= pbc_pkg::WR_DATA_FIRST) begin
							shift_ff <= nxt_shift;
						end
						if (cnt_ff == pbc_pkg::WR_DATA_LAST) begin
							mdio_wr_ff <= (mreg_ff == pbc_pkg::REG_CTRL);
							mstate_ff <= M_PRE;
						end
					end
				end
				M_RD: begin
					if (mdc_fall) begin
						cnt_ff <= cnt_ff + 5'h01;
						if (cnt_ff > pbc_pkg::RD_TA_DRIVE) begin
							shift_ff <= {shift_ff[14:0], 1'b0};
						end
						if (cnt_ff == pbc_pkg::RD_RELEASE) begin
							mstate_ff <= M_PRE;
						end
					end
				end
				default: begin
					mstate_ff <= M_PRE;
				end
			endcase
		end
	end

	// Data pin driver; idle pin released so other stations can answer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mdio_o_ff <= 1'b1;
			mdio_oen_ff <= 1'b1;
		end else if (mstate_ff == M_RD && mdc_fall) begin
			if (cnt_ff == pbc_pkg::RD_TA_DRIVE) begin
				mdio_o_ff <= 1'b0;
				mdio_oen_ff <= 1'b0;
			end else if (cnt_ff > pbc_pkg::RD_TA_DRIVE && cnt_ff < pbc_pkg::RD_RELEASE) begin
				mdio_o_ff <= shift_ff[15];
				mdio_oen_ff <= 1'b0;
			end else begin
				mdio_o_ff <= 1'b1;
				mdio_oen_ff <= 1'b1;
			end
		end else if (mstate_ff != M_RD) begin
			mdio_o_ff <= 1'b1;
			mdio_oen_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Write arbitration
	// ------------------------------------------------------------
	// both paths reach the same bank; serial write wins a tie
	always_comb begin
		wr_valid = 1'b0;
		wr_port = 2'h0;
		wr_data = 16'h0000;
		if (mdio_wr_ff) begin
			wr_valid = 1'b1;
			wr_port = mport_ff;
			wr_data = shift_ff;
		end else if (spi_req.wr && spi_req.regad == pbc_pkg::REG_CTRL &&
			{1'b0, spi_req.port} < 3'(NUM_PORTS)) begin
			wr_valid = 1'b1;
			wr_port = spi_req.port;
			wr_data = spi_req.wdata;
		end
	end

	// ------------------------------------------------------------
	// Control register bank
	// ------------------------------------------------------------
	// Soft reset restores defaults and holds bit 15 until the timer ends
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < 4; p++) begin
				ctl_ff[p] <= pbc_pkg::CTRL_RESET;
				rst_cnt_ff[p] <= 5'h00;
			end
		end else begin
			for (int p = 0; p < 4; p++) begin
				if (wr_valid && wr_port == 2'(p) && wr_data[pbc_pkg::B_SOFT_RESET]) begin
					ctl_ff[p] <= pbc_pkg::CTRL_RESET | 16'h8000;
					rst_cnt_ff[p] <= 5'(pbc_pkg::SOFT_RESET_CYC);
				end else if (wr_valid && wr_port == 2'(p)) begin
					ctl_ff[p] <= apply_write(wr_data);
				end else if (rst_cnt_ff[p] == 5'h01) begin
					ctl_ff[p][pbc_pkg::B_SOFT_RESET] <= 1'b0;
					rst_cnt_ff[p] <= 5'h00;
				end else if (rst_cnt_ff[p] != 5'h00) begin
					rst_cnt_ff[p] <= rst_cnt_ff[p] - 5'h01;
				end
			end
		end
	end

	// SPI read answer one cycle after the request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			spi_rdata_ff <= 16'h0000;
			spi_rvalid_ff <= 1'b0;
		end else begin
			spi_rvalid_ff <= spi_req.rd;
			if (spi_req.rd) begin
				spi_rdata_ff <= (spi_req.regad == pbc_pkg::REG_CTRL &&
					{1'b0, spi_req.port} < 3'(NUM_PORTS)) ? ctl_ff[spi_req.port] : 16'h0000;
			end
		end
	end

	// ------------------------------------------------------------
	// Per-port PHY controls
	// ------------------------------------------------------------
	// Decoded from the bank, restart pulse from the write itself; unused ports stay at rest
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_ctl_ff <= '0;
		end else begin
			for (int p = 0; p < 4; p++) begin
				if (p < NUM_PORTS) begin
					// reset held while bit 15 stands
					port_ctl_ff[p].soft_reset <= ctl_ff[p][pbc_pkg::B_SOFT_RESET];
					port_ctl_ff[p].mac_loopback <= ctl_ff[p][pbc_pkg::B_LOOPBACK];
					port_ctl_ff[p].autoneg_enable <= ctl_ff[p][pbc_pkg::B_AUTONEG_ENABLE];
					if (!ctl_ff[p][pbc_pkg::B_AUTONEG_ENABLE]) begin
						port_ctl_ff[p].speed_100 <= ctl_ff[p][pbc_pkg::B_SPEED_100];
						port_ctl_ff[p].full_duplex <= ctl_ff[p][pbc_pkg::B_FULL_DUPLEX];
					end
					port_ctl_ff[p].power_down <= ctl_ff[p][pbc_pkg::B_POWER_DOWN];
					port_ctl_ff[p].line_isolate <= ctl_ff[p][pbc_pkg::B_ISOLATE];
					port_ctl_ff[p].autoneg_restart <= wr_valid && wr_port == 2'(p) &&
						wr_data[pbc_pkg::B_AN_RESTART] && !wr_data[pbc_pkg::B_SOFT_RESET];
					port_ctl_ff[p].crossover_algorithm_select <= ctl_ff[p][pbc_pkg::B_XOVER_ALG];
					port_ctl_ff[p].auto_crossover_disable <= ctl_ff[p][pbc_pkg::B_XOVER_DISABLE];
					// fixed pairs apply only when detection is off
					port_ctl_ff[p].fixed_pair_straight_select <=
						ctl_ff[p][pbc_pkg::B_XOVER_DISABLE] & ctl_ff[p][pbc_pkg::B_PAIR_STRAIGHT];
					port_ctl_ff[p].far_end_fault_disable <= ctl_ff[p][pbc_pkg::B_FEF_DISABLE];
					port_ctl_ff[p].tx_disable <= ctl_ff[p][pbc_pkg::B_TX_DISABLE];
					port_ctl_ff[p].led_disable <= ctl_ff[p][pbc_pkg::B_LED_DISABLE];
				end
			end
		end
	end
endmodule // pbc_top

// ### design/pbc_pkg.sv
// Package: constants, field layout and carrier types of the PHY basic control bank
package pbc_pkg;
	// ------------------------------------------------------------
	// Register map and field positions
	// ------------------------------------------------------------
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] PHYAD_FIRST = 5'h01;
	localparam int B_SOFT_RESET = 15;
	localparam int B_LOOPBACK = 14;
	localparam int B_SPEED_100 = 13;
	localparam int B_AUTONEG_ENABLE = 12;
	localparam int B_POWER_DOWN = 11;
	localparam int B_ISOLATE = 10;
	localparam int B_AN_RESTART = 9;
	localparam int B_FULL_DUPLEX = 8;
	localparam int B_XOVER_ALG = 5;
	localparam int B_PAIR_STRAIGHT = 4;
	localparam int B_XOVER_DISABLE = 3;
	localparam int B_FEF_DISABLE = 2;
	localparam int B_TX_DISABLE = 1;
	localparam int B_LED_DISABLE = 0;
	localparam logic [15:0] CTRL_RESET = 16'h3120;
	localparam logic [15:0] CTRL_WMASK = 16'hFF3F;
	// ------------------------------------------------------------
	// Management frame fields
	// ------------------------------------------------------------
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [1:0] FRAME_START = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [4:0] HDR_LAST = 5'h0D;
	localparam logic [4:0] WR_DATA_FIRST = 5'h02;
	localparam logic [4:0] WR_DATA_LAST = 5'h11;
	localparam logic [4:0] RD_TA_DRIVE = 5'h01;
	localparam logic [4:0] RD_RELEASE = 5'h12;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SOFT_RESET_NS = 1000;
	localparam int SOFT_RESET_CYC = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] port;
		logic [4:0] regad;
		logic [15:0] wdata;
	} pbc_spi_req_t;
	typedef struct packed {
		logic soft_reset;
		logic mac_loopback;
		logic speed_100;
		logic full_duplex;
		logic autoneg_enable;
		logic power_down;
		logic line_isolate;
		logic autoneg_restart;
		logic crossover_algorithm_select;
		logic fixed_pair_straight_select;
		logic auto_crossover_disable;
		logic far_end_fault_disable;
		logic tx_disable;
		logic led_disable;
	} pbc_port_ctl_t;
endpackage

// ### verification/pbc_monitor.sv
// Checker of the PHY basic control bank, bound to its top module
`timescale 1ns/100ps
module pbc_monitor #(
	parameter int NUM_PORTS = 4
) (
	input wire logic clk, // System clock
	input wire logic rstn, // Reset, active low
	input wire logic mdc, // Management clock
	input wire logic mdio_i, // Management data in
	input wire logic mdio_o_ff, // Management data out
	input wire logic mdio_oen_ff, // Management enable, low drives
	input wire pbc_pkg::pbc_spi_req_t spi_req, // SPI request
	input wire logic [15:0] spi_rdata_ff, // SPI read data
	input wire logic spi_rvalid_ff, // SPI read valid
	input wire pbc_pkg::pbc_port_ctl_t [3:0] port_ctl_ff // Port controls
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// --------
	// Sequences
	// --------
	// Plain SPI write of port 0 control, soft reset bit clear
	sequence s_wr1;
		spi_req.wr && spi_req.port == 2'h0 && spi_req.regad == 5'h00 && !spi_req.wdata[15];
	endsequence
	// Soft reset stands a while before clearing; timer is twenty cycles
	sequence s_sr_hold;
		port_ctl_ff[0].soft_reset [*8];
	endsequence
	// --------
	// Assertions
	// --------
	a_read_answer: assert property (spi_req.rd |=> spi_rvalid_ff)
		else $error("read not answered");
	a_no_spurious: assert property (!spi_req.rd |=> !spi_rvalid_ff)
		else $error("valid without read");
	a_reserved_zero: assert property (spi_rvalid_ff |-> spi_rdata_ff[7:6] == 2'h0)
		else $error("reserved bits read back");
	a_loop_follow: assert property (s_wr1 |-> ##2 port_ctl_ff[0].mac_loopback == $past(spi_req.wdata[14], 2))
		else $error("loopback not applied");
	a_power_follow: assert property (s_wr1 |-> ##2 port_ctl_ff[0].power_down == $past(spi_req.wdata[11], 2))
		else $error("power down not applied");
	a_forced_speed: assert property (s_wr1 ##0 !spi_req.wdata[12] |-> ##2 port_ctl_ff[0].speed_100 == $past(spi_req.wdata[13], 2))
		else $error("forced speed not applied");
	a_restart_pulse: assert property (s_wr1 ##0 spi_req.wdata[9] |-> ##1 port_ctl_ff[0].autoneg_restart ##1 !port_ctl_ff[0].autoneg_restart)
		else $error("restart pulse wrong");
	a_soft_clear: assert property ($rose(port_ctl_ff[0].soft_reset) |-> s_sr_hold ##[8:17] !port_ctl_ff[0].soft_reset)
		else $error("soft reset clear timing");
	a_turn_zero: assert property ($fell(mdio_oen_ff) |-> !mdio_o_ff)
		else $error("turnaround not zero");
	a_unused_port: assert property (NUM_PORTS < 4 |-> port_ctl_ff[3] == 14'h0000)
		else $error("unmapped port moved");
endmodule // pbc_monitor
bind pbc_top pbc_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (.clk(clk), .rstn(rstn), .mdc(mdc),
	.mdio_i(mdio_i), .mdio_o_ff(mdio_o_ff), .mdio_oen_ff(mdio_oen_ff), .spi_req(spi_req),
	.spi_rdata_ff(spi_rdata_ff), .spi_rvalid_ff(spi_rvalid_ff), .port_ctl_ff(port_ctl_ff));

// ### verification/pbc_mdio_host.sv
// Station management host model for the serial management bus
`timescale 1ns/100ps
module pbc_mdio_host (
	input wire logic clk, // System clock
	output logic mdc, // Management clock, still between frames
	output logic mdio_i, // Resolved data wire
	input wire logic mdio_o_ff, // Device data
	input wire logic mdio_oen_ff // Device enable, low drives
);
	logic hd; // Host level, 1 when released
	// Pulled-up wire, either party may pull it low
	assign mdio_i = hd & (mdio_oen_ff | mdio_o_ff);
	// Idle state before the first frame
	initial begin
		mdc = 1'b0;
		hd = 1'b1;
	end
	// One bit: six clocks low, four high; low is longer since the device answers late
	task automatic bit_io(input logic b, output logic s);
		#1 mdc = 1'b0;
		hd = b;
		repeat (6) @(posedge clk);
		#1 s = mdio_i;
		mdc = 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] hdr;
		logic s;
		hdr = {2'b01, op, phy, ra, op == pbc_pkg::OP_READ ? 2'b11 : 2'b10, wd};
		rd = 16'h0000;
		@(posedge clk);
		repeat (32) bit_io(1'b1, s);
		for (int i = 31; i >= 0; i--) begin
			bit_io(hdr[i], s);
			rd = {rd[14:0], s};
		end
		#1 mdc = 1'b0;
		hd = 1'b1;
		repeat (12) @(posedge clk);
	endtask
endmodule // pbc_mdio_host

// ### verification/pbc_top_bench.sv
// Self-checking bench of the PHY basic control bank
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module pbc_top_bench;
	logic clk, rstn, mdc, mdio_i, mdio_o_ff, mdio_oen_ff, spi_rvalid_ff;
	logic [15:0] spi_rdata_ff, d;
	pbc_pkg::pbc_spi_req_t spi_req;
	pbc_pkg::pbc_port_ctl_t [3:0] port_ctl_ff;
	int fail_count, num_checks;
	logic [15:0] wv [3] = '{16'h4EDF, 16'h2100, 16'h1030};
	logic [13:0] cv [3] = '{14'h119F, 14'h0C00, 14'h0E20};
	// Three ports only, so the fourth is an unmapped place
	pbc_top #(.NUM_PORTS(3)) uut (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_i(mdio_i),
		.mdio_o_ff(mdio_o_ff), .mdio_oen_ff(mdio_oen_ff), .spi_req(spi_req),
		.spi_rdata_ff(spi_rdata_ff), .spi_rvalid_ff(spi_rvalid_ff), .port_ctl_ff(port_ctl_ff));
	pbc_mdio_host host (.clk(clk), .mdc(mdc), .mdio_i(mdio_i), .mdio_o_ff(mdio_o_ff),
		.mdio_oen_ff(mdio_oen_ff));
	// --------
	// Clock, tasks and tests
	// --------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// One SPI request for one cycle; a read leaves its data in d
	task automatic spi(input logic w, input logic [1:0] p, input logic [4:0] a,
		input logic [15:0] wd);
		@(posedge clk) #1;
		spi_req = {w, ~w, p, a, wd};
		@(posedge clk) #1;
		spi_req = '0;
		d = spi_rdata_ff;
		if (!w) `CHK(spi_rvalid_ff, 1'b1)
	endtask
	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Watchdog: about 2700 clocks expected, over seven times that allowed
	initial begin
		#1000000;
		fail_count++;
		stop_test;
	end
	// Main sequence
	initial begin
		rstn = 1'b0;
		spi_req = '0;
		fail_count = 0;
		num_checks = 0;
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		for (int p = 0; p < 3; p++) begin
			spi(1'b0, p[1:0], 5'h00, 16'h0000);
			`CHK(d, 16'h3120)
		end
		`CHK(port_ctl_ff[0], 14'h0220)
		$display("test reset values done");
		for (int i = 0; i < 3; i++) begin
			spi(1'b1, 2'h0, 5'h00, wv[i]);
			spi(1'b0, 2'h0, 5'h00, 16'h0000);
			`CHK(d, wv[i] & pbc_pkg::CTRL_WMASK)
			`CHK(port_ctl_ff[0], cv[i])
		end
		`CHK(port_ctl_ff[1], 14'h0220)
		$display("test field controls done");
		spi(1'b1, 2'h1, 5'h01, 16'hFFFF);
		spi(1'b0, 2'h1, 5'h01, 16'h0000);
		`CHK(d, 16'h0000)
		spi(1'b1, 2'h3, 5'h00, 16'h0C00);
		spi(1'b0, 2'h3, 5'h00, 16'h0000);
		`CHK(d, 16'h0000)
		$display("test refused places done");
		spi(1'b1, 2'h0, 5'h00, 16'h8000);
		spi(1'b0, 2'h0, 5'h00, 16'h0000);
		`CHK(d, 16'hB120)
		repeat (25) @(posedge clk);
		spi(1'b0, 2'h0, 5'h00, 16'h0000);
		`CHK(d, 16'h3120)
		$display("test soft reset done");
		host.frame(pbc_pkg::OP_WRITE, 5'h02, 5'h00, 16'h0900, d);
		spi(1'b0, 2'h1, 5'h00, 16'h0000);
		`CHK(d, 16'h0900)
		`CHK(port_ctl_ff[1].power_down, 1'b1)
		host.frame(pbc_pkg::OP_READ, 5'h02, 5'h00, 16'hFFFF, d);
		`CHK(d, 16'h0900)
		host.frame(pbc_pkg::OP_READ, 5'h01, 5'h01, 16'hFFFF, d);
		`CHK(d, 16'h0000)
		host.frame(pbc_pkg::OP_READ, 5'h04, 5'h00, 16'hFFFF, d);
		`CHK(d, 16'hFFFF)
		$display("test serial bus done");
		stop_test;
	end
endmodule // pbc_top_bench
